// File: src/dct_params.svh
// How it works
// - edge detector pulses on rising or falling edge per edge select field
// - pulses shorter than glitch filter width are dropped before edge detection
// - short counter idle output is inverse of its initial-level bit
// - long counter idle output in normal or ping-pong is inverse of initial bit
// - transmit mode 10 or 11 forces long output to 0 or 1
// - enabling long counter loads high*256+low and sets output to initial level
// - long terminal count toggles output outside demod, sets status, interrupts if enabled
// - long counter stops in single-pass, reloads in modulo-N
// - reload bytes writable anytime, used only at next load
// - demod with bit D6 set: short timeout captures long value, no reload
// - writing mode bit 0 then 1 arms capture and reload on next edge
// - in demodulation the long counter wraps to FFFF and flags timeout
// - ping-pong starts when either counter enable is set
// - short counter in ping-pong loads high or low time by output level
// - counters hand over to each other at terminal count in ping-pong
// - each counter interrupts at its own terminal count in ping-pong
// - writing 00 to transmit mode field ends ping-pong
// - stopping and restarting a counter reloads its initial value
// - counters keep running while the core is halted
// - short counter reloads in modulo-N, stops in single-pass
// - short timeout status set at terminal count, cleared by writing 1
`ifndef DCT_PARAMS_SVH
`define DCT_PARAMS_SVH
// register offsets
`define DCT_OFS_SHORT_CTL 4'h0
`define DCT_OFS_MODE_CTL 4'h1
`define DCT_OFS_LONG_CTL 4'h2
`define DCT_OFS_LONG_HI 4'h3
`define DCT_OFS_LONG_LO 4'h4
`define DCT_OFS_SHORT_HI 4'h5
`define DCT_OFS_SHORT_LO 4'h6
`define DCT_OFS_CAPT_HI 4'h7
`define DCT_OFS_CAPT_LO 4'h8
// short control bits
`define DCT_SC_EN 7
`define DCT_SC_SINGLE 6
`define DCT_SC_TOUT 5
`define DCT_SC_IE 1
// mode control bits
`define DCT_MC_TXMODE 7
`define DCT_MC_EDGE_HI 5
`define DCT_MC_EDGE_LO 4
`define DCT_MC_FILT_HI 3
`define DCT_MC_FILT_LO 2
`define DCT_MC_SINIT 1
`define DCT_MC_LINIT 0
// long control bits
`define DCT_LC_EN 7
`define DCT_LC_MODE 6
`define DCT_LC_TOUT 5
`define DCT_LC_INSEL 4
`define DCT_LC_CIE 2
`define DCT_LC_IE 1
// reset and wrap values
`define DCT_RST_BYTE 8'h00
`define DCT_WRAP_VAL 16'hFFFF
// glitch widths in clock cycles for filter codes 1..3
`define DCT_FILT_W1 4'h2
`define DCT_FILT_W2 4'h4
`define DCT_FILT_W3 4'h8
`endif

// File: src/dct_pkg.sv
package dct_pkg;
  typedef enum logic [1:0] {DCT_TX_NORMAL, DCT_TX_PINGPONG, DCT_TX_FORCE0, DCT_TX_FORCE1} dct_tx_type;
  typedef enum logic [1:0] {DCT_EDGE_NONE, DCT_EDGE_FALL, DCT_EDGE_RISE, DCT_EDGE_BOTH} dct_edge_type;
endpackage : dct_pkg

// File: src/dct_unit.sv
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ns
`include "dct_params.svh"
module dct_unit (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // capture pins
  input wire logic CAPTURE_INPUT_A,
  input wire logic CAPTURE_INPUT_B,
  // outputs
  output logic SHORT_COUNTER_OUTPUT,
  output logic LONG_COUNTER_OUTPUT,
  output logic SHORT_IRQ,
  output logic LONG_IRQ
);
  logic [7:0] sc_ctl_ff, mc_ctl_ff, lc_ctl_ff;
  logic [7:0] lhi_ff, llo_ff, shi_ff, slo_ff;
  logic [15:0] capt_ff, lcnt_ff;
  logic [7:0] scnt_ff;
  logic sout_ff, lout_ff, s_run_ff, l_run_ff, armed_ff, first_ff;
  logic [1:0] sync_a_ff, sync_b_ff;
  logic filt_ff, filt_d_ff;
  logic [3:0] glitch_ff;
  logic [7:0] rdata_ff;
  logic wr_sc, wr_mc, wr_lc;
  logic [1:0] txm;
  logic pingpong, demod, raw_in, pos_edge, neg_edge, edge_hit;
  logic s_tc, l_tc, s_start, l_start;
  logic [3:0] filt_w;

  assign wr_sc = WR && (ADDR == `DCT_OFS_SHORT_CTL);
  assign wr_mc = WR && (ADDR == `DCT_OFS_MODE_CTL);
  assign wr_lc = WR && (ADDR == `DCT_OFS_LONG_CTL);
  assign txm = mc_ctl_ff[`DCT_MC_FILT_HI:`DCT_MC_FILT_LO];
  // transmit mode field shares bits with filter; filter applies only in demod
  assign demod = !mc_ctl_ff[`DCT_MC_TXMODE];
  assign pingpong = !demod && (txm == dct_pkg::DCT_TX_PINGPONG);
  assign s_tc = s_run_ff && (scnt_ff == 8'h00);
  assign l_tc = l_run_ff && (lcnt_ff == 16'h0000);

  // pin synchronisers, first stage read only by second
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sync_a_ff <= 2'h0;
      sync_b_ff <= 2'h0;
    end else begin
      sync_a_ff <= {sync_a_ff[0], CAPTURE_INPUT_A};
      sync_b_ff <= {sync_b_ff[0], CAPTURE_INPUT_B};
    end
  end
  assign raw_in = lc_ctl_ff[`DCT_LC_INSEL] ? sync_b_ff[1] : sync_a_ff[1];

  // glitch filter: new level accepted only after stable for filt_w+1 cycles
  always_comb begin
    unique case (txm)
      2'h1: filt_w = `DCT_FILT_W1;
      2'h2: filt_w = `DCT_FILT_W2;
      2'h3: filt_w = `DCT_FILT_W3;
      default: filt_w = 4'h0;
    endcase
  end
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      glitch_ff <= 4'h0;
      filt_ff <= 1'b0;
      filt_d_ff <= 1'b0;
    end else begin
      filt_d_ff <= filt_ff;
      if (raw_in == filt_ff) begin
        glitch_ff <= 4'h0;
      end else if (glitch_ff >= filt_w) begin
        filt_ff <= raw_in;
        glitch_ff <= 4'h0;
      end else begin
        glitch_ff <= glitch_ff + 4'h1;
      end
    end
  end
  // edge detector on filtered level
  assign pos_edge = filt_ff && !filt_d_ff;
  assign neg_edge = !filt_ff && filt_d_ff;
  assign edge_hit = (mc_ctl_ff[`DCT_MC_EDGE_HI] && pos_edge) || (mc_ctl_ff[`DCT_MC_EDGE_LO] && neg_edge);

  // ping-pong hand-over starts
  assign s_start = pingpong && l_tc;
  assign l_start = pingpong && s_tc;

  // control registers; hardware status set wins over software clear
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sc_ctl_ff <= `DCT_RST_BYTE;
      mc_ctl_ff <= `DCT_RST_BYTE;
      lc_ctl_ff <= `DCT_RST_BYTE;
    end else begin
      if (wr_mc) begin
        mc_ctl_ff <= WDATA;
      end
      if (wr_sc) begin
        sc_ctl_ff[7:6] <= WDATA[7:6];
        sc_ctl_ff[4:0] <= WDATA[4:0];
        if (WDATA[`DCT_SC_TOUT]) begin
          sc_ctl_ff[`DCT_SC_TOUT] <= 1'b0;
        end
      end
      if (s_tc) begin
        sc_ctl_ff[`DCT_SC_TOUT] <= 1'b1;
        if (sc_ctl_ff[`DCT_SC_SINGLE] || pingpong) begin
          sc_ctl_ff[`DCT_SC_EN] <= 1'b0;
        end
      end
      if (s_start) begin
        sc_ctl_ff[`DCT_SC_EN] <= 1'b1;
      end
      if (wr_lc) begin
        lc_ctl_ff[7:6] <= WDATA[7:6];
        lc_ctl_ff[4:0] <= WDATA[4:0];
        if (WDATA[`DCT_LC_TOUT]) begin
          lc_ctl_ff[`DCT_LC_TOUT] <= 1'b0;
        end
      end
      if (l_tc) begin
        lc_ctl_ff[`DCT_LC_TOUT] <= 1'b1;
        if (!demod && (lc_ctl_ff[`DCT_LC_MODE] || pingpong)) begin
          lc_ctl_ff[`DCT_LC_EN] <= 1'b0;
        end
      end
      if (l_start) begin
        lc_ctl_ff[`DCT_LC_EN] <= 1'b1;
      end
    end
  end

  // reload bytes, read only at load time
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      lhi_ff <= `DCT_RST_BYTE;
      llo_ff <= `DCT_RST_BYTE;
      shi_ff <= `DCT_RST_BYTE;
      slo_ff <= `DCT_RST_BYTE;
    end else begin
      if (WR && ADDR == `DCT_OFS_LONG_HI) lhi_ff <= WDATA;
      if (WR && ADDR == `DCT_OFS_LONG_LO) llo_ff <= WDATA;
      if (WR && ADDR == `DCT_OFS_SHORT_HI) shi_ff <= WDATA;
      if (WR && ADDR == `DCT_OFS_SHORT_LO) slo_ff <= WDATA;
    end
  end

  // short counter; runs regardless of core halt
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_run_ff <= 1'b0;
      scnt_ff <= 8'h00;
      sout_ff <= 1'b1;
    end else if (!sc_ctl_ff[`DCT_SC_EN] || (demod && !sc_ctl_ff[`DCT_SC_EN])) begin
      s_run_ff <= 1'b0;
      sout_ff <= !mc_ctl_ff[`DCT_MC_SINIT];
    end else if (!s_run_ff) begin
      s_run_ff <= 1'b1;
      sout_ff <= mc_ctl_ff[`DCT_MC_SINIT];
      scnt_ff <= mc_ctl_ff[`DCT_MC_SINIT] ? shi_ff : slo_ff;
    end else if (s_tc) begin
      if (sc_ctl_ff[`DCT_SC_SINGLE] || pingpong) begin
        s_run_ff <= 1'b0;
      end else begin
        sout_ff <= !sout_ff;
        scnt_ff <= sout_ff ? slo_ff : shi_ff;
      end
    end else begin
      scnt_ff <= scnt_ff - 8'h01;
    end
  end

  // long counter, transmit and demodulation
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      l_run_ff <= 1'b0;
      lcnt_ff <= 16'h0000;
      lout_ff <= 1'b1;
      capt_ff <= 16'h0000;
      armed_ff <= 1'b0;
      first_ff <= 1'b0;
    end else begin
      first_ff <= lc_ctl_ff[`DCT_LC_MODE];
      if (demod && lc_ctl_ff[`DCT_LC_MODE] && !first_ff) begin
        armed_ff <= 1'b1;
      end
      if (!lc_ctl_ff[`DCT_LC_EN]) begin
        l_run_ff <= 1'b0;
        lout_ff <= !mc_ctl_ff[`DCT_MC_LINIT];
      end else if (!l_run_ff) begin
        l_run_ff <= 1'b1;
        lcnt_ff <= {lhi_ff, llo_ff};
        lout_ff <= mc_ctl_ff[`DCT_MC_LINIT];
      end else if (demod && armed_ff && edge_hit) begin
        capt_ff <= lcnt_ff;
        lcnt_ff <= {lhi_ff, llo_ff};
        armed_ff <= 1'b0;
      end else if (l_tc) begin
        if (demod) begin
          lcnt_ff <= `DCT_WRAP_VAL;
        end else begin
          lout_ff <= !lout_ff;
          if (lc_ctl_ff[`DCT_LC_MODE] || pingpong) begin
            l_run_ff <= 1'b0;
          end else begin
            lcnt_ff <= {lhi_ff, llo_ff};
          end
        end
      end else begin
        lcnt_ff <= lcnt_ff - 16'h0001;
        if (demod && lc_ctl_ff[`DCT_LC_MODE] && s_tc) begin
          capt_ff <= lcnt_ff;
        end
      end
    end
  end

  // outputs; forced levels override long output
  always_comb begin
    SHORT_COUNTER_OUTPUT = sout_ff;
    LONG_COUNTER_OUTPUT = lout_ff;
    if (!demod && txm == dct_pkg::DCT_TX_FORCE0) LONG_COUNTER_OUTPUT = 1'b0;
    if (!demod && txm == dct_pkg::DCT_TX_FORCE1) LONG_COUNTER_OUTPUT = 1'b1;
  end
  // interrupt requests are one-cycle pulses
  assign SHORT_IRQ = s_tc && sc_ctl_ff[`DCT_SC_IE];
  assign LONG_IRQ = (l_tc && lc_ctl_ff[`DCT_LC_IE])
    || (demod && lc_ctl_ff[`DCT_LC_MODE] && s_tc && lc_ctl_ff[`DCT_LC_CIE]);

  // read port, data one cycle after strobe
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_ff <= 8'h00;
    end else if (RD) begin
      unique case (ADDR)
        `DCT_OFS_SHORT_CTL: rdata_ff <= sc_ctl_ff;
        `DCT_OFS_MODE_CTL: rdata_ff <= mc_ctl_ff;
        `DCT_OFS_LONG_CTL: rdata_ff <= lc_ctl_ff;
        `DCT_OFS_LONG_HI: rdata_ff <= lhi_ff;
        `DCT_OFS_LONG_LO: rdata_ff <= llo_ff;
        `DCT_OFS_SHORT_HI: rdata_ff <= shi_ff;
        `DCT_OFS_SHORT_LO: rdata_ff <= slo_ff;
        `DCT_OFS_CAPT_HI: rdata_ff <= capt_ff[15:8];
        `DCT_OFS_CAPT_LO: rdata_ff <= capt_ff[7:0];
        default: rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end
  assign RDATA = rdata_ff;
endmodule : dct_unit

// File: dv/dct_carrier_model.sv
`timescale 1ns/1ns
module dct_carrier_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // burst request
  input wire logic fire,
  input wire logic [4:0] width,
  // carrier pins, A low and B high between bursts
  output logic pin_a,
  output logic pin_b
);
  logic [4:0] left_ff;
  // carrier stays high for width cycles after each request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) left_ff <= 5'h00;
    else if (fire) left_ff <= width;
    else if (left_ff != 5'h00) left_ff <= left_ff - 5'h01;
  end
  assign pin_a = (left_ff != 5'h00);
  assign pin_b = ~pin_a; // unselected pin differs so a wrong select shows
endmodule : dct_carrier_model

// File: dv/dct_unit_assertions.sv
`timescale 1ns/1ns
module dct_checker (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // register port
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // pins and requests
  input wire logic CAPTURE_INPUT_A,
  input wire logic CAPTURE_INPUT_B,
  input wire logic SHORT_COUNTER_OUTPUT,
  input wire logic LONG_COUNTER_OUTPUT,
  input wire logic SHORT_IRQ,
  input wire logic LONG_IRQ
);
  logic [7:0] mode_ff;
  logic [2:0] ie_ff;
  // shadow only software-owned bits, hardware never alters them
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) {mode_ff, ie_ff} <= 11'h000;
    else if (WR && ADDR == 4'h1) mode_ff <= WDATA;
    else if (WR && ADDR == 4'h0) ie_ff[0] <= WDATA[1];
    else if (WR && ADDR == 4'h2) ie_ff[2:1] <= WDATA[2:1];
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  // disabling write, a quiet cycle, then the output flop has settled
  sequence stop_seen(a);
    WR && ADDR == a && !WDATA[7] && !WDATA[5] ##1 !WR ##1 1'b1;
  endsequence
  chk_read_quiet: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside its cycle");
  chk_short_pulse: assert property (SHORT_IRQ |=> !SHORT_IRQ)
    else $error("short request too long");
  chk_long_pulse: assert property (LONG_IRQ |=> !LONG_IRQ)
    else $error("long request too long");
  chk_short_mask: assert property (SHORT_IRQ |-> ie_ff[0])
    else $error("short request while masked");
  chk_long_mask: assert property (LONG_IRQ |-> ie_ff[1] || ie_ff[2])
    else $error("long request while masked");
  chk_force_low: assert property (mode_ff[7] && mode_ff[3:2] == 2'b10 |-> !LONG_COUNTER_OUTPUT)
    else $error("long output not forced low");
  chk_force_high: assert property (mode_ff[7] && mode_ff[3:2] == 2'b11 |-> LONG_COUNTER_OUTPUT)
    else $error("long output not forced high");
  chk_short_idle: assert property (stop_seen(4'h0) |-> !mode_ff[7] || mode_ff[3:2] == 2'b01 ||
    SHORT_COUNTER_OUTPUT == !mode_ff[1]) else $error("short idle level wrong");
  chk_long_idle: assert property (stop_seen(4'h2) |-> !mode_ff[7] || mode_ff[3:2] != 2'b00 ||
    LONG_COUNTER_OUTPUT == !mode_ff[0]) else $error("long idle level wrong");
endmodule : dct_checker
bind dct_unit dct_checker i_chk (.REF_CLK(REF_CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .CAPTURE_INPUT_A(CAPTURE_INPUT_A), .CAPTURE_INPUT_B(CAPTURE_INPUT_B),
  .SHORT_COUNTER_OUTPUT(SHORT_COUNTER_OUTPUT), .LONG_COUNTER_OUTPUT(LONG_COUNTER_OUTPUT),
  .SHORT_IRQ(SHORT_IRQ), .LONG_IRQ(LONG_IRQ));

// File: dv/test_dual_counter_timer_unit.sv
`timescale 1ns/1ns
module test_dual_counter_timer_unit;
  logic clk = 1'b0, rn = 1'b0, wr = 1'b0, rd = 1'b0, fire = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wd = 8'h00;
  logic [4:0] wid = 5'h00;
  logic [7:0] rdata;
  logic ca, cb, so, lo, si, li, lvl;
  int miscompares = 0, num_checks = 0, n;
  // 10 MHz reference
  always #50 clk = ~clk;
  dct_unit i_dut (.REF_CLK(clk), .RESETN(rn), .ADDR(addr), .WDATA(wd), .WR(wr), .RD(rd), .RDATA(rdata),
    .CAPTURE_INPUT_A(ca), .CAPTURE_INPUT_B(cb), .SHORT_COUNTER_OUTPUT(so), .LONG_COUNTER_OUTPUT(lo),
    .SHORT_IRQ(si), .LONG_IRQ(li));
  dct_carrier_model i_far (.clk(clk), .rst_n(rn), .fire(fire), .width(wid), .pin_a(ca), .pin_b(cb));
  task chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s, saw %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // data stands only in the cycle after the strobe
  task rd_chk(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata & m, e, "read");
  endtask : rd_chk
  task lvl_chk(input logic [7:0] e);
    repeat (2) @(negedge clk);
    chk({6'h00, so, lo}, e, "levels");
  endtask : lvl_chk
  // bounded wait; n comes back as the cycle count
  task wait_irq(input logic lng, input int lim);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((lng ? li : si) !== 1'b1 && n < lim);
  endtask : wait_irq
  task burst(input logic [4:0] w);
    @(posedge clk);
    wid <= w;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (30) @(posedge clk);
  endtask : burst
  task wrap_up;
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // watchdog: about 500 cycles needed, 5000 allowed
  initial begin
    #500000;
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge clk);
    rn <= 1'b1;
    lvl_chk(8'h03);
    rd_chk(4'hF, 8'h00, 8'hFF);
    wr_reg(4'h1, 8'h88);
    lvl_chk(8'h02);
    wr_reg(4'h1, 8'h8C);
    lvl_chk(8'h03);
    wr_reg(4'h1, 8'h83);
    wr_reg(4'h0, 8'h00);
    wr_reg(4'h2, 8'h00);
    lvl_chk(8'h00);
    wr_reg(4'h1, 8'h80);
    lvl_chk(8'h03);
    $display("levels test done");
    wr_reg(4'h4, 8'h05);
    wr_reg(4'h2, 8'h82);
    lvl_chk(8'h02);
    wait_irq(1'b1, 50);
    lvl = lo;
    wait_irq(1'b1, 50);
    chk(8'(n), 8'h06, "period");
    chk({7'h00, lo}, {7'h00, ~lvl}, "toggle");
    wr_reg(4'h4, 8'h09);
    wait_irq(1'b1, 50);
    wait_irq(1'b1, 50);
    chk(8'(n), 8'h0A, "reload");
    rd_chk(4'h2, 8'h20, 8'h20);
    wr_reg(4'h2, 8'h00);
    wr_reg(4'h2, 8'h20);
    rd_chk(4'h2, 8'h00, 8'hFF);
    wr_reg(4'h2, 8'hC2);
    wait_irq(1'b1, 50);
    wait_irq(1'b1, 60);
    chk(8'(n), 8'h3C, "single stop");
    wr_reg(4'h5, 8'h04);
    wr_reg(4'h6, 8'h04);
    wr_reg(4'h0, 8'hC2);
    wait_irq(1'b0, 40);
    chk({7'h00, n < 40}, 8'h01, "short end");
    wait_irq(1'b0, 40);
    chk(8'(n), 8'h28, "short stop");
    rd_chk(4'h0, 8'h20, 8'h20);
    wr_reg(4'h0, 8'h20);
    rd_chk(4'h0, 8'h00, 8'h20);
    $display("counting test done");
    wr_reg(4'h1, 8'h84);
    wr_reg(4'h2, 8'h62);
    wr_reg(4'h0, 8'h42);
    wr_reg(4'h0, 8'hC2);
    lvl_chk(8'h01);
    repeat (2) begin
      wait_irq(1'b0, 40);
      chk({7'h00, n < 40}, 8'h01, "ping short");
      wait_irq(1'b1, 40);
      chk({7'h00, n < 40}, 8'h01, "ping long");
    end
    wr_reg(4'h1, 8'h80);
    repeat (30) @(negedge clk);
    wait_irq(1'b0, 60);
    chk(8'(n), 8'h3C, "ping end");
    $display("ping-pong test done");
    wr_reg(4'h1, 8'h2C);
    wr_reg(4'h3, 8'hFF);
    wr_reg(4'h4, 8'h00);
    wr_reg(4'h2, 8'h80);
    wr_reg(4'h2, 8'hC0);
    burst(5'h03);
    rd_chk(4'h7, 8'h00, 8'hFF);
    burst(5'h14);
    rd_chk(4'h7, 8'hFE, 8'hFF);
    // short timeout snapshots the long count while it keeps running
    wr_reg(4'h0, 8'h82);
    wr_reg(4'h2, 8'hC4);
    wait_irq(1'b1, 40);
    chk({7'h00, n < 40}, 8'h01, "capture request");
    rd_chk(4'h7, 8'hFE, 8'hFF);
    // long count from 8 must wrap to the top, not reload
    wr_reg(4'h2, 8'h00);
    wr_reg(4'h3, 8'h00);
    wr_reg(4'h4, 8'h08);
    wr_reg(4'h2, 8'h82);
    wait_irq(1'b1, 40);
    chk({7'h00, n < 40}, 8'h01, "wrap request");
    wr_reg(4'h2, 8'hC6);
    wait_irq(1'b1, 40);
    chk({7'h00, n < 40}, 8'h01, "wrap capture");
    rd_chk(4'h7, 8'hFF, 8'hFF);
    $display("capture test done");
    wrap_up();
  end
endmodule : test_dual_counter_timer_unit
